// [ocld_attr_mem.sv]
`timescale 1ns/10ps
package ocld_pkg;
  // apb map, byte addresses
  localparam logic [11:0] OCLD_CFG_OFF    = 12'h000;
  localparam logic [11:0] OCLD_STATUS_OFF = 12'h004;
  localparam logic [11:0] OCLD_MASK_OFF   = 12'h008;
  localparam logic [11:0] OCLD_LAST_OFF   = 12'h00C;
  localparam logic [11:0] OCLD_COUNT_OFF  = 12'h010;
  localparam logic [11:0] OCLD_TBL_BASE   = 12'h100;
  localparam logic [11:0] OCLD_TBL_LAST   = 12'h1FC;

  // cfg register fields
  localparam int OCLD_CFG_REL2_BIT    = 0;
  localparam int OCLD_CFG_SIMD_IMPL   = 1;
  localparam int OCLD_CFG_SIMD_EN     = 2;
  localparam int OCLD_CFG_DBG_IMPL    = 3;
  localparam int OCLD_CFG_EXT_IMPL    = 4;
  localparam int OCLD_CFG_COP_LSB     = 8;
  localparam int OCLD_CFG_W           = 12;
  localparam logic [11:0] OCLD_CFG_RST = 12'h002;

  // status / mask event bits
  localparam int OCLD_EV_RI   = 0;
  localparam int OCLD_EV_CPU  = 1;
  localparam int OCLD_EV_SIMD = 2;
  localparam int OCLD_EV_OBS  = 3;
  localparam int OCLD_EV_W    = 4;

  // last register layout
  localparam int OCLD_LAST_CAUSE_LSB = 8;

  // instruction fields
  localparam int OCLD_OP_HI  = 31;
  localparam int OCLD_OP_LO  = 26;
  localparam int OCLD_RS_HI  = 25;
  localparam int OCLD_RS_LO  = 21;
  localparam int OCLD_MIN_HI = 5;
  localparam int OCLD_MIN_LO = 0;

  localparam logic [5:0] OCLD_OP_COPROC_ONE = 6'h11;
  localparam logic [5:0] OCLD_OP_SIMD = 6'h1E;
  localparam logic [3:0] OCLD_COP_ROW = 4'h4;

  // valid simd minor opcodes, one bit per value
  localparam logic [63:0] OCLD_SIMD_MINOR_OK = 64'h0000_00FF_5E3F_E6C7;
  // simd branch rs values: 01011, 01111, 11000..11111
  localparam logic [31:0] OCLD_SIMD_BR_RS    = 32'hFF00_8800;

  // per-opcode attribute word
  localparam int OCLD_ATTR_W = 10;
  typedef struct packed {
    logic coproc;
    logic field_class;
    logic obsolete;
    logic rel2_only;
    logic app_ext;
    logic debug_op;
    logic partner;
    logic compat64;
    logic higher_level;
    logic reserved;
  } ocld_attr_type;

  typedef enum logic [3:0] {
    OCLD_CAUSE_NONE = 4'b0001,
    OCLD_CAUSE_RI   = 4'b0010,
    OCLD_CAUSE_CPU  = 4'b0100,
    OCLD_CAUSE_SIMD = 4'b1000
  } ocld_cause_type;

  typedef struct packed {
    logic           valid;
    logic [5:0]     opcode;
    logic           secondary;
    logic           simd_op;
    logic           simd_branch;
    logic           obsolete;
    logic           commit_ok;
    ocld_cause_type cause;
  } ocld_result_type;

  typedef struct packed {
    logic       kernel_mode;
    logic       debug_mode;
    logic       ux64_enable;
  } ocld_mode_type;
endpackage

// opcode attribute table, registered read, cleared by reset
module ocld_attr_mem
  import ocld_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          wr_en,
  input  wire logic [5:0]    wr_addr,
  input  wire ocld_attr_type wr_data,
  input  wire logic [5:0]    rd_addr,
  output ocld_attr_type      rd_data_ff
);
  ocld_attr_type mem_ff [64];

  // one entry per opcode, all attribute bits clear until software marks them
  genvar gi;
  generate
    for (gi = 0; gi < 64; gi++) begin : g_entry
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem_ff[gi] <= '0;
        end else if (wr_en && (wr_addr == 6'(gi))) begin
          mem_ff[gi] <= wr_data;
        end
      end
    end
  endgenerate

  // read data from a register to line up with the fetch stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_ff <= '0;
    end else begin
      rd_data_ff <= mem_ff[rd_addr];
    end
  end
endmodule // ocld_attr_mem

// [ocld_decoder.sv]
`timescale 1ns/10ps
// What this block does
// - opcode is bits 31..29 as row and bits 28..26 as column.
// - reserved operation or field codes raise reserved instruction.
// - field class opcodes decode a further field before identifying the instruction.
// - encodings of a higher architecture level raise reserved instruction.
// - compat-restricted ops run in kernel, debug, or with 64-bit ops enabled.
// - otherwise reserved instruction, or coprocessor unusable for inaccessible coprocessor.
// - unused partner encodings: reserved instruction, or unusable if coprocessor inaccessible.
// - debug-support encodings raise reserved instruction when not implemented.
// - extension encodings raise reserved instruction when the extension is absent.
// - release 2 encodings run on release 2, raise reserved instruction on release 1.
// - simd ops under opcode 30, simd branches in opcode 17 by ten rs values.
// - reserved simd minor opcodes raise simd-disabled or reserved instruction.
module ocld_decoder
  import ocld_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic            instr_valid,
  input  wire logic [31:0]     instr_word,
  input  wire ocld_mode_type   core_mode,
  output ocld_result_type      dec_result,
  output logic                 irq
);
  logic [OCLD_CFG_W-1:0] cfg_ff;
  logic [OCLD_EV_W-1:0]  status_ff;
  logic [OCLD_EV_W-1:0]  mask_ff;
  logic [31:0]           last_ff;
  logic [31:0]           count_ff;
  logic [31:0]           prdata_ff;
  logic                  pready_ff;
  logic                  pslverr_ff;
  logic                  irq_ff;
  ocld_result_type       result_ff;
  logic                  s1_valid_ff;
  logic [31:0]           s1_word_ff;
  ocld_mode_type         s1_mode_ff;
  ocld_attr_type         s1_attr;
  ocld_result_type       nxt_result;
  logic [OCLD_EV_W-1:0]  ev_set;
  logic                  wr_access;
  logic                  tbl_hit;
  logic                  tbl_wr;

  // table window decode, used by write and error paths
  function automatic logic is_tbl(input logic [11:0] a);
    return (a >= OCLD_TBL_BASE) && (a <= OCLD_TBL_LAST) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    return is_tbl(a) || (a == OCLD_CFG_OFF) || (a == OCLD_STATUS_OFF) ||
           (a == OCLD_MASK_OFF) || (a == OCLD_LAST_OFF) || (a == OCLD_COUNT_OFF);
  endfunction

  // coprocessor fault choice shared by compat and partner cases
  function automatic ocld_cause_type cop_cause(input logic is_cop, input logic cop_ok);
    return (is_cop && !cop_ok) ? OCLD_CAUSE_CPU : OCLD_CAUSE_RI;
  endfunction

  assign tbl_hit   = is_tbl(paddr);
  assign wr_access = psel && penable && pready_ff && pwrite;
  assign tbl_wr    = wr_access && tbl_hit;

  ocld_attr_mem u_attr_mem (
    .pclk       (pclk),
    .presetn    (presetn),
    .wr_en      (tbl_wr),
    .wr_addr    (paddr[7:2]),
    .wr_data    (ocld_attr_type'(pwdata[OCLD_ATTR_W-1:0])),
    .rd_addr    (instr_word[OCLD_OP_HI:OCLD_OP_LO]),
    .rd_data_ff (s1_attr)
  );

  // fetch stage capture, aligned with the registered table read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_valid_ff <= 1'b0;
      s1_word_ff  <= 32'h0000_0000;
      s1_mode_ff  <= '0;
    end else begin
      s1_valid_ff <= instr_valid;
      s1_word_ff  <= instr_word;
      s1_mode_ff  <= core_mode;
    end
  end

  // legality decision; the first matching fault wins so only one cause is ever reported
  always_comb begin
    logic [5:0]     op;
    logic [4:0]     rs;
    logic [5:0]     minor;
    logic [1:0]     cop_num;
    logic           cop_ok;
    logic           mode_ok;
    logic           is_simd;
    logic           is_cp_one;
    ocld_cause_type cause;
    op          = s1_word_ff[OCLD_OP_HI:OCLD_OP_LO];
    rs          = s1_word_ff[OCLD_RS_HI:OCLD_RS_LO];
    minor       = s1_word_ff[OCLD_MIN_HI:OCLD_MIN_LO];
    cop_num     = op[1:0];
    cop_ok      = cfg_ff[OCLD_CFG_COP_LSB + 32'(cop_num)];
    mode_ok     = s1_mode_ff.kernel_mode || s1_mode_ff.debug_mode ||
                  s1_mode_ff.ux64_enable;
    is_simd     = (op == OCLD_OP_SIMD);
    is_cp_one   = (op == OCLD_OP_COPROC_ONE);
    cause       = OCLD_CAUSE_NONE;
    nxt_result  = '0;
    nxt_result.valid       = s1_valid_ff;
    nxt_result.opcode      = op;
    nxt_result.obsolete    = s1_attr.obsolete;
    // class entries look at a second field before naming the instruction
    nxt_result.secondary   = s1_attr.field_class || is_simd || is_cp_one;
    nxt_result.simd_op     = is_simd;
    nxt_result.simd_branch = is_cp_one && OCLD_SIMD_BR_RS[rs];
    if (s1_attr.reserved) begin
      cause = OCLD_CAUSE_RI;
    end else if (s1_attr.higher_level) begin
      cause = OCLD_CAUSE_RI;
    end else if (s1_attr.rel2_only && !cfg_ff[OCLD_CFG_REL2_BIT]) begin
      cause = OCLD_CAUSE_RI;
    end else if (s1_attr.app_ext && !cfg_ff[OCLD_CFG_EXT_IMPL]) begin
      cause = OCLD_CAUSE_RI;
    end else if (s1_attr.debug_op && !cfg_ff[OCLD_CFG_DBG_IMPL]) begin
      cause = OCLD_CAUSE_RI;
    end else if (s1_attr.compat64 && !mode_ok) begin
      cause = cop_cause(s1_attr.coproc, cop_ok);
    end else if (s1_attr.partner) begin
      cause = cop_cause(s1_attr.coproc, cop_ok);
    end else if (is_simd) begin
      // reserved minors follow the same enable split as the valid ones
      if (!cfg_ff[OCLD_CFG_SIMD_IMPL]) begin
        cause = OCLD_CAUSE_RI;
      end else if (!cfg_ff[OCLD_CFG_SIMD_EN]) begin
        cause = OCLD_CAUSE_SIMD;
      end else if (!OCLD_SIMD_MINOR_OK[minor]) begin
        cause = OCLD_CAUSE_RI;
      end
    end else if (nxt_result.simd_branch) begin
      if (!cop_ok) begin
        cause = OCLD_CAUSE_CPU;
      end else if (!cfg_ff[OCLD_CFG_SIMD_IMPL]) begin
        cause = OCLD_CAUSE_RI;
      end else if (!cfg_ff[OCLD_CFG_SIMD_EN]) begin
        cause = OCLD_CAUSE_SIMD;
      end
    end else if (s1_attr.coproc && (op[5:2] == OCLD_COP_ROW) && !cop_ok) begin
      cause = OCLD_CAUSE_CPU;
    end
    nxt_result.cause     = cause;
    // a faulting instruction must not write registers or memory
    nxt_result.commit_ok = s1_valid_ff && (cause == OCLD_CAUSE_NONE);
  end

  // result register toward execution and exception logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_ff <= '{cause: OCLD_CAUSE_NONE, default: '0};
    end else begin
      result_ff <= nxt_result;
    end
  end

  // events of this cycle, only for valid instructions
  always_comb begin
    ev_set               = '0;
    ev_set[OCLD_EV_RI]   = nxt_result.valid && (nxt_result.cause == OCLD_CAUSE_RI);
    ev_set[OCLD_EV_CPU]  = nxt_result.valid && (nxt_result.cause == OCLD_CAUSE_CPU);
    ev_set[OCLD_EV_SIMD] = nxt_result.valid && (nxt_result.cause == OCLD_CAUSE_SIMD);
    ev_set[OCLD_EV_OBS]  = nxt_result.valid && nxt_result.obsolete;
  end

  // sticky status, write one to clear; a same-cycle event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= '0;
    end else if (wr_access && (paddr == OCLD_STATUS_OFF)) begin
      status_ff <= (status_ff & ~pwdata[OCLD_EV_W-1:0]) | ev_set;
    end else begin
      status_ff <= status_ff | ev_set;
    end
  end

  // configuration and mask, written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff  <= OCLD_CFG_RST;
      mask_ff <= '0;
    end else if (wr_access) begin
      if (paddr == OCLD_CFG_OFF) begin
        cfg_ff <= pwdata[OCLD_CFG_W-1:0];
      end
      if (paddr == OCLD_MASK_OFF) begin
        mask_ff <= pwdata[OCLD_EV_W-1:0];
      end
    end
  end

  // last faulting opcode and cause, plus a running fault count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_ff  <= 32'h0000_0000;
      count_ff <= 32'h0000_0000;
    end else if (nxt_result.valid && (nxt_result.cause != OCLD_CAUSE_NONE)) begin
      last_ff  <= {20'h0_0000, nxt_result.cause, 2'b00, nxt_result.opcode};
      count_ff <= count_ff + 32'h0000_0001;
    end else if (wr_access && (paddr == OCLD_COUNT_OFF)) begin
      count_ff <= 32'h0000_0000;
    end
  end

  // level interrupt, registered so the pin is glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(status_ff & mask_ff);
    end
  end

  // apb slave: data and ready prepared in setup, so every access has one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && !is_mapped(paddr);
      prdata_ff  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        // table entries are write-only; reading them returns zero
        case (paddr)
          OCLD_CFG_OFF:    prdata_ff <= 32'(cfg_ff);
          OCLD_STATUS_OFF: prdata_ff <= 32'(status_ff);
          OCLD_MASK_OFF:   prdata_ff <= 32'(mask_ff);
          OCLD_LAST_OFF:   prdata_ff <= last_ff;
          OCLD_COUNT_OFF:  prdata_ff <= count_ff;
          default:         prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata     = prdata_ff;
  assign pready     = pready_ff;
  assign pslverr    = pslverr_ff;
  assign irq        = irq_ff;
  assign dec_result = result_ff;
endmodule // ocld_decoder

// [ocld_decoder_asserts.sv]
`timescale 1ns/10ps
// port-level checks on bus timing, decode latency and fault reporting
module ocld_decoder_chk
  import ocld_pkg::*;
(
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic            instr_valid,
  input wire logic [31:0]     instr_word,
  input wire ocld_result_type dec_result,
  input wire logic            irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // events that may legitimately lift the interrupt line
  logic ev;
  logic apw;
  assign ev  = dec_result.valid && (dec_result.cause != OCLD_CAUSE_NONE || dec_result.obsolete);
  assign apw = psel && penable && pready && pwrite;

  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready in the access cycle");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held beyond one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  a_result_latency: assert property (instr_valid |-> ##2 dec_result.valid)
    else $error("decode result missing two cycles after issue");
  a_opcode_rows: assert property (
    instr_valid |-> ##2 dec_result.opcode == $past(instr_word[31:26], 2))
    else $error("opcode not taken from bits 31 to 26");
  a_single_cause: assert property (dec_result.valid |-> $onehot(dec_result.cause))
    else $error("more than one cause reported");
  a_fault_no_commit: assert property (
    dec_result.valid && dec_result.cause != OCLD_CAUSE_NONE |-> !dec_result.commit_ok)
    else $error("faulting instruction allowed to commit");
  a_simd_major: assert property (
    instr_valid && instr_word[31:26] == OCLD_OP_SIMD |-> ##2 dec_result.simd_op)
    else $error("simd major opcode not recognised");
  a_simd_branch: assert property (
    instr_valid && instr_word[31:26] == OCLD_OP_COPROC_ONE && OCLD_SIMD_BR_RS[instr_word[25:21]]
    |-> ##2 dec_result.simd_branch)
    else $error("simd branch rs value not recognised");
  a_irq_cause: assert property ($rose(irq) |-> $past(ev) || $past(apw) || $past(apw, 2))
    else $error("interrupt rose without an event or register write");
endmodule // ocld_decoder_chk

bind ocld_decoder ocld_decoder_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .instr_valid(instr_valid), .instr_word(instr_word), .dec_result(dec_result), .irq(irq));

// [ocld_fetch_model.sv]
`timescale 1ns/10ps
// fetch stage stand-in: one word per request, one cycle after it
module ocld_fetch_model
  import ocld_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          issue,
  input  wire logic [31:0]   word_in,
  input  wire ocld_mode_type mode_in,
  output logic               instr_valid,
  output logic [31:0]        instr_word,
  output ocld_mode_type      core_mode
);
  // idle word and mode invert every cycle so no stale value looks valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_valid <= 1'b0;
      instr_word  <= 32'h0000_0000;
      core_mode   <= '0;
    end else begin
      instr_valid <= issue;
      instr_word  <= issue ? word_in : ~instr_word;
      core_mode   <= issue ? mode_in : ~core_mode;
    end
  end
endmodule // ocld_fetch_model

// [test_opcode_class_legality_decoder.sv]
`timescale 1ns/10ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp); end end
module test_opcode_class_legality_decoder
  import ocld_pkg::*;
;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, issue, err;
  logic            instr_valid;
  logic [11:0]     paddr, cfg;
  logic [31:0]     pwdata, prdata, word_in, instr_word, rd, seed, r, r2, w;
  logic [9:0]      attr_m [64];
  ocld_mode_type   mode_in, core_mode;
  ocld_result_type res;
  int              mismatches, cmp_count, cyc, faults;

  ocld_fetch_model i_fetch (.pclk(pclk), .presetn(presetn), .issue(issue), .word_in(word_in),
    .mode_in(mode_in), .instr_valid(instr_valid), .instr_word(instr_word), .core_mode(core_mode));
  ocld_decoder i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr_valid(instr_valid), .instr_word(instr_word),
    .core_mode(core_mode), .dec_result(res), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // hang guard, well above the few thousand cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (mismatches == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // one apb transfer; starts on an edge, held until ready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no assumed latency; only the hang guard ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // expected cause, in the priority order the decoder settles on
  function automatic ocld_cause_type exp_cause(input logic [31:0] iw, input logic [9:0] a,
      input logic [11:0] c, input ocld_mode_type m);
    logic cop_op, cop_ok, priv, br;
    cop_op = a[9] && iw[31:28] == OCLD_COP_ROW;
    cop_ok = c[8 + iw[27:26]];
    priv = m.kernel_mode | m.debug_mode | m.ux64_enable;
    br = iw[31:26] == OCLD_OP_COPROC_ONE && OCLD_SIMD_BR_RS[iw[25:21]];
    if (a[0] || a[1] || (a[6] && !c[0]) || (a[5] && !c[4]) || (a[4] && !c[3]))
      return OCLD_CAUSE_RI;
    // any coprocessor encoding counts here, not only the generic coprocessor row
    if ((a[2] && !priv) || a[3])
      return (a[9] && !cop_ok) ? OCLD_CAUSE_CPU : OCLD_CAUSE_RI;
    if (br && !c[9])
      return OCLD_CAUSE_CPU;
    if (iw[31:26] == OCLD_OP_SIMD || br) begin
      if (!c[1])
        return OCLD_CAUSE_RI;
      if (!c[2])
        return OCLD_CAUSE_SIMD;
      if (!br && !OCLD_SIMD_MINOR_OK[iw[5:0]])
        return OCLD_CAUSE_RI;
    end
    return (cop_op && !cop_ok) ? OCLD_CAUSE_CPU : OCLD_CAUSE_NONE;
  endfunction

  // issue one word through the fetch model and judge the result
  task automatic send(input logic [31:0] iw, input ocld_mode_type m);
    ocld_cause_type e;
    logic           sec;
    logic           br;
    @(posedge pclk);
    issue <= 1'b1;
    word_in <= iw;
    mode_in <= m;
    @(posedge pclk);
    issue <= 1'b0;
    // fetch model adds one edge, decoder two more
    repeat (2) @(posedge pclk);
    #1;
    e = exp_cause(iw, attr_m[iw[31:26]], cfg, m);
    sec = attr_m[iw[31:26]][8] || iw[31:26] == OCLD_OP_SIMD || iw[31:26] == OCLD_OP_COPROC_ONE;
    br = iw[31:26] == OCLD_OP_COPROC_ONE && OCLD_SIMD_BR_RS[iw[25:21]];
    if (e != OCLD_CAUSE_NONE) faults++;
    `CHK(res.valid, 1'b1)
    `CHK(res.opcode, iw[31:26])
    `CHK(res.cause, e)
    `CHK(res.commit_ok, e == OCLD_CAUSE_NONE)
    `CHK(res.secondary, sec)
    `CHK(res.obsolete, attr_m[iw[31:26]][7])
    `CHK(res.simd_op, iw[31:26] == OCLD_OP_SIMD)
    `CHK(res.simd_branch, br)
  endtask

  initial begin
    seed = 32'h6728_cfc8;
    {presetn, psel, penable, pwrite, issue} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    word_in = 32'h0000_0000;
    mode_in = '0;
    cfg = OCLD_CFG_RST;
    foreach (attr_m[i]) attr_m[i] = 10'h000;
    repeat (10) @(posedge pclk);
    `CHK(irq, 1'b0)
    `CHK(res.cause, OCLD_CAUSE_NONE)
    presetn <= 1'b1;
    @(posedge pclk);
    // reset value, unmapped place, write-only table
    apb(1'b0, OCLD_CFG_OFF, 32'h0000_0000);
    `CHK(rd, {20'h0_0000, OCLD_CFG_RST})
    apb(1'b0, 12'h020, 32'h0000_0000);
    `CHK(err, 1'b1)
    apb(1'b0, OCLD_TBL_BASE, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    // interrupt: raise, clear, then masked out
    apb(1'b1, OCLD_MASK_OFF, 32'h0000_0001);
    attr_m[63] = 10'h001;
    apb(1'b1, OCLD_TBL_LAST, 32'h0000_0001);
    send(32'hFC00_0000, '0);
    @(posedge pclk);
    #1;
    `CHK(irq, 1'b1)
    apb(1'b0, OCLD_STATUS_OFF, 32'h0000_0000);
    `CHK(rd[OCLD_EV_RI], 1'b1)
    apb(1'b1, OCLD_STATUS_OFF, 32'h0000_0001);
    @(posedge pclk);
    #1;
    `CHK(irq, 1'b0)
    apb(1'b1, OCLD_MASK_OFF, 32'h0000_0000);
    send(32'hFC00_0000, '0);
    @(posedge pclk);
    #1;
    `CHK(irq, 1'b0)
    apb(1'b1, OCLD_MASK_OFF, 32'h0000_000F);
    // random attributes, config and modes; simd and coprocessor-one opcodes favoured
    for (int k = 0; k < 300; k++) begin
      r = $random(seed);
      w = $random(seed);
      w[31:26] = (r[1:0] == 2'd0) ? OCLD_OP_SIMD : (r[1:0] == 2'd1) ? OCLD_OP_COPROC_ONE : r[7:2];
      r2 = $random(seed) & $random(seed) & $random(seed);
      attr_m[w[31:26]] = r2[9:0];
      r2 = $random(seed) & 32'h0000_0F1F;
      cfg = r2[11:0];
      apb(1'b1, OCLD_TBL_BASE + {4'h0, w[31:26], 2'b00}, {22'h00_0000, attr_m[w[31:26]]});
      apb(1'b1, OCLD_CFG_OFF, {20'h0_0000, cfg});
      send(w, r[10:8]);
    end
    // fault counter must have seen every faulting instruction sent
    apb(1'b0, OCLD_COUNT_OFF, 32'h0000_0000);
    `CHK(rd, faults)
    end_sim();
  end
endmodule // test_opcode_class_legality_decoder
